// ### gfsm_mux.sv
// per-pin function multiplexer for the five general-purpose pins
//
// Overview of operation
// - each of five pins has its own code; the code alone picks its source
// - pins one to four take all codes; fifth pin a reduced subset
// - code 01h drives the level bit as output; input is a level input
// - codes 02h and 03h drive the first and second interrupt lines
// - code 04h drives the derived clock from the system clock
// - codes 05h and 06h drive the two locked-loop clock outputs
// - 07h drives the S/PDIF output; 08h and 09h the two PWM outputs
// - 0Ah and 0Bh show system and asynchronous clock underclock errors
// - 0Ch and 0Dh show lock of the two locked loops
// - 0Fh and 10h show that the two loop clock outputs are active
// - 12h is high once headphone detection has completed
// - 13h emits one 31 us pulse per microphone accessory event that arrives while no pulse runs
// - 15h emits a short pulse when the write sequencer finishes all
// - 16h is high while a control interface address error is flagged
// - 1Ah and 1Bh show lock of the two rate converters
// - 1Ch is high while the rate converter configuration is in error
// - 1Dh is high while the dynamics signal threshold is exceeded
// - 1Eh and 1Fh show dynamics anti-clip and decay activity
// - 20h is high while the dynamics noise gate is active
// - 21h is high while the dynamics quick release is active
// - 27h shows a sample dropped in the core mixers
// - direction bit clear makes an output, set makes an input
// - polarity bit set inverts the selected source of an output pin
// - drive type bit clear is push-pull, set is open drain
`timescale 1ns/1ps
module gfsm_mux
  import gfsm_pkg::*;
#(
  parameter int NP = GFSM_NUM_PINS,
  parameter logic [63:0] P5_MASK = PIN5_CODE_MASK
) (
  input wire logic sys_clk,                          // system clock
  input wire logic rst_b,                            // async reset, active low
  input wire logic cfg_we,                           // config write strobe
  input wire logic [2:0] cfg_pin,                    // pin index 0..4
  input wire logic [6:0] cfg_pin_function_code,      // function code
  input wire logic cfg_pin_direction_bit,            // 1 input, 0 output
  input wire logic cfg_pin_level_bit,                // output level
  input wire logic cfg_output_polarity_bit,          // 1 inverts
  input wire logic cfg_output_drive_type_bit,        // 1 open drain
  input wire logic first_interrupt_line,             // interrupt line a
  input wire logic second_interrupt_line,            // interrupt line b
  input wire logic derived_clock_output,             // derived clock
  input wire logic first_locked_loop_clk,            // loop a clock
  input wire logic second_locked_loop_clk,           // loop b clock
  input wire logic spdif_out,                        // S/PDIF stream
  input wire logic pwm_a,                            // pwm a
  input wire logic pwm_b,                            // pwm b
  input wire logic system_clock_underclk,            // sys underclock
  input wire logic asynchronous_clock_underclk,      // async underclock
  input wire logic first_locked_loop_lock,           // loop a lock
  input wire logic second_locked_loop_lock,          // loop b lock
  input wire logic first_locked_loop_ok,             // loop a clock ok
  input wire logic second_locked_loop_ok,            // loop b clock ok
  input wire logic hp_detect_done,                   // headphone detect done
  input wire logic mic_accessory_detect_evt,         // accessory event pulse
  input wire logic wseq_all_done,                    // sequencer done pulse
  input wire logic cif_addr_err,                     // control addr error
  input wire logic first_rate_converter_lock,        // rc a lock
  input wire logic second_rate_converter_lock,       // rc b lock
  input wire logic async_rate_converter_cfg_err,     // rc config error
  input wire logic first_dynamics_processor_sig,     // signal detect
  input wire logic first_dynamics_processor_clip,    // anti-clip active
  input wire logic first_dynamics_processor_decay,   // decay active
  input wire logic first_dynamics_processor_gate,    // noise gate active
  input wire logic first_dynamics_processor_qrel,    // quick release active
  input wire logic mixer_drop,                       // mixer dropped sample
  input wire logic [NP-1:0] pin_in,                  // pad input levels
  output logic [NP-1:0] pin_out,                     // pad output value
  output logic [NP-1:0] pin_oe,                      // pad output enable
  output logic [NP-1:0] pin_in_level,                // sampled input level
  output logic [6:0] pin_function_code_rd [NP]       // current codes
);
  logic [6:0] fn_q [NP];
  logic [NP-1:0] dir_q;
  logic [NP-1:0] lvl_q;
  logic [NP-1:0] pol_q;
  logic [NP-1:0] odr_q;
  logic mic_pulse;
  logic wseq_q;
  logic [NP-1:0] sel_valid;
  logic [NP-1:0] sel_src;
  logic [NP-1:0] out_d;
  logic [NP-1:0] out_q;
  logic [NP-1:0] oe_d;
  logic [NP-1:0] oe_q;
  logic [NP-1:0] in_q;

  // accessory event stretched to a fixed-width pulse
  gfsm_pulse_stretch #(
    .LEN(MIC_PULSE_CYC),
    .CW(MIC_CNT_W)
  ) u_mic_pulse (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .trig(mic_accessory_detect_evt),
    .pulse(mic_pulse)
  );

  // sequencer completion registered, delayed by one cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wseq_q <= 1'b0;
    end else begin
      wseq_q <= wseq_all_done;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_pin
      // per-pin configuration fields
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          fn_q[g] <= FN_RESET;
          dir_q[g] <= DIR_RESET;
          lvl_q[g] <= LVL_RESET;
          pol_q[g] <= POL_RESET;
          odr_q[g] <= ODR_RESET;
        end else if (cfg_we && cfg_pin == 3'(g)) begin
          fn_q[g] <= cfg_pin_function_code;
          dir_q[g] <= cfg_pin_direction_bit;
          lvl_q[g] <= cfg_pin_level_bit;
          pol_q[g] <= cfg_output_polarity_bit;
          odr_q[g] <= cfg_output_drive_type_bit;
        end
      end

      // source selection by code
      always_comb begin
        sel_valid[g] = 1'b1;
        sel_src[g] = 1'b0;
        unique case (fn_q[g])
          FN_LOGIC: sel_src[g] = lvl_q[g];
          FN_IRQ_A: sel_src[g] = first_interrupt_line;
          FN_IRQ_B: sel_src[g] = second_interrupt_line;
          FN_DCLK: sel_src[g] = derived_clock_output;
          FN_LOOP_A_CLK: sel_src[g] = first_locked_loop_clk;
          FN_LOOP_B_CLK: sel_src[g] = second_locked_loop_clk;
          FN_SPDIF: sel_src[g] = spdif_out;
          FN_PWM_A: sel_src[g] = pwm_a;
          FN_PWM_B: sel_src[g] = pwm_b;
          FN_SYS_UNDER: sel_src[g] = system_clock_underclk;
          FN_ASY_UNDER: sel_src[g] = asynchronous_clock_underclk;
          FN_LOOP_A_LOCK: sel_src[g] = first_locked_loop_lock;
          FN_LOOP_B_LOCK: sel_src[g] = second_locked_loop_lock;
          FN_LOOP_A_OK: sel_src[g] = first_locked_loop_ok;
          FN_LOOP_B_OK: sel_src[g] = second_locked_loop_ok;
          FN_HP_DET: sel_src[g] = hp_detect_done;
          FN_MIC_DET: sel_src[g] = mic_pulse;
          FN_WSEQ_DONE: sel_src[g] = wseq_q;
          FN_CIF_ERR: sel_src[g] = cif_addr_err;
          FN_RC_A_LOCK: sel_src[g] = first_rate_converter_lock;
          FN_RC_B_LOCK: sel_src[g] = second_rate_converter_lock;
          FN_RC_CFG_ERR: sel_src[g] = async_rate_converter_cfg_err;
          FN_DYN_SIG: sel_src[g] = first_dynamics_processor_sig;
          FN_DYN_CLIP: sel_src[g] = first_dynamics_processor_clip;
          FN_DYN_DECAY: sel_src[g] = first_dynamics_processor_decay;
          FN_DYN_GATE: sel_src[g] = first_dynamics_processor_gate;
          FN_DYN_QREL: sel_src[g] = first_dynamics_processor_qrel;
          FN_MIX_DROP: sel_src[g] = mixer_drop;
          default: sel_valid[g] = 1'b0;
        endcase
        // fifth pin only honours its subset
        if (g == NP - 1 && fn_q[g][6] == 1'b0 && !P5_MASK[fn_q[g][5:0]]) begin
          sel_valid[g] = 1'b0;
        end
        if (g == NP - 1 && fn_q[g][6] == 1'b1) begin
          sel_valid[g] = 1'b0;
        end
      end

      // pad drive: polarity, direction and drive type
      always_comb begin
        out_d[g] = 1'b0;
        oe_d[g] = 1'b0;
        if (!dir_q[g] && sel_valid[g]) begin
          if (odr_q[g]) begin
            out_d[g] = 1'b0;
            oe_d[g] = ~(sel_src[g] ^ pol_q[g]);
          end else begin
            out_d[g] = sel_src[g] ^ pol_q[g];
            oe_d[g] = 1'b1;
          end
        end
      end

      // registered pad outputs and input level
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          out_q[g] <= 1'b0;
          oe_q[g] <= 1'b0;
          in_q[g] <= 1'b0;
        end else begin
          out_q[g] <= out_d[g];
          oe_q[g] <= oe_d[g];
          in_q[g] <= pin_in[g];
        end
      end

      assign pin_function_code_rd[g] = fn_q[g];

      // input direction never drives the pad
      property p_input_no_drive;
        @(posedge sys_clk) disable iff (!rst_b)
          dir_q[g] |=> !oe_q[g];
      endproperty
      a_input_no_drive: assert property (p_input_no_drive)
        else $error("input pin driven");

      // no-function code leaves the pad undriven
      property p_none_no_drive;
        @(posedge sys_clk) disable iff (!rst_b)
          (fn_q[g] == FN_NONE) |=> !oe_q[g];
      endproperty
      a_none_no_drive: assert property (p_none_no_drive)
        else $error("no-function pin driven");

      // push-pull logic level follows level xor polarity
      property p_logic_level;
        @(posedge sys_clk) disable iff (!rst_b)
          (fn_q[g] == FN_LOGIC && !dir_q[g] && !odr_q[g])
            |=> (oe_q[g] && out_q[g] == ($past(lvl_q[g]) ^ $past(pol_q[g])));
      endproperty
      a_logic_level: assert property (p_logic_level)
        else $error("logic level output wrong");

      // open drain never drives high
      property p_open_drain;
        @(posedge sys_clk) disable iff (!rst_b)
          (!dir_q[g] && odr_q[g]) |=> !out_q[g];
      endproperty
      a_open_drain: assert property (p_open_drain)
        else $error("open drain drove high");

      // first interrupt line routed with polarity
      property p_irq_route;
        @(posedge sys_clk) disable iff (!rst_b)
          (fn_q[g] == FN_IRQ_A && !dir_q[g] && !odr_q[g])
            |=> out_q[g] == ($past(first_interrupt_line) ^ $past(pol_q[g]));
      endproperty
      a_irq_route: assert property (p_irq_route)
        else $error("interrupt routing wrong");

      // mixer flag routed with polarity
      property p_mix_route;
        @(posedge sys_clk) disable iff (!rst_b)
          (fn_q[g] == FN_MIX_DROP && !dir_q[g] && !odr_q[g])
            |=> out_q[g] == ($past(mixer_drop) ^ $past(pol_q[g]));
      endproperty
      a_mix_route: assert property (p_mix_route)
        else $error("mixer flag routing wrong");

      // input level is the pad sampled one cycle back
      property p_input_level;
        @(posedge sys_clk) disable iff (!rst_b)
          dir_q[g] |=> in_q[g] == $past(pin_in[g]);
      endproperty
      a_input_level: assert property (p_input_level)
        else $error("input level wrong");

      // open drain pulls low exactly when the selected value xor polarity is low
      property p_od_pull;
        @(posedge sys_clk) disable iff (!rst_b)
          (!dir_q[g] && odr_q[g] && sel_valid[g])
            |=> oe_q[g] == !($past(sel_src[g]) ^ $past(pol_q[g]));
      endproperty
      a_od_pull: assert property (p_od_pull)
        else $error("open drain pull wrong");
    end
  endgenerate

  assign pin_out = out_q;
  assign pin_oe = oe_q;
  assign pin_in_level = in_q;

  // write addressed to pin 0 lands in that pin's field
  property p_cfg_write;
    @(posedge sys_clk) disable iff (!rst_b)
      (cfg_we && cfg_pin == 3'd0) |=> fn_q[0] == $past(cfg_pin_function_code);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("function code not stored");

  // fifth pin drives nothing for a code outside its subset
  property p_pin5_refused;
    @(posedge sys_clk) disable iff (!rst_b)
      (fn_q[NP-1][6] == 1'b0 && !P5_MASK[fn_q[NP-1][5:0]]) |=> !oe_q[NP-1];
  endproperty
  a_pin5_refused: assert property (p_pin5_refused)
    else $error("fifth pin refused code drove the pad");

  // accessory pulse: event then at least eight cycles high
  sequence s_mic_evt;
    mic_accessory_detect_evt && !mic_pulse;
  endsequence
  sequence s_mic_hold;
    mic_pulse [*8];
  endsequence
  property p_mic_pulse;
    @(posedge sys_clk) disable iff (!rst_b)
      s_mic_evt |=> s_mic_hold;
  endproperty
  a_mic_pulse: assert property (p_mic_pulse)
    else $error("accessory pulse too short");

  // helper: cycles the accessory pulse has been high so far
  logic [MIC_CNT_W-1:0] mic_len_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mic_len_q <= '0;
    end else if (mic_pulse) begin
      mic_len_q <= mic_len_q + 1'b1;
    end else begin
      mic_len_q <= '0;
    end
  end

  // accessory pulse never outlasts its length
  property p_mic_end;
    @(posedge sys_clk) disable iff (!rst_b)
      mic_pulse |-> mic_len_q < MIC_CNT_W'(MIC_PULSE_CYC);
  endproperty
  a_mic_end: assert property (p_mic_end)
    else $error("accessory pulse too long");

  // accessory pulse ends exactly at its length
  property p_mic_full;
    @(posedge sys_clk) disable iff (!rst_b)
      $fell(mic_pulse) |-> mic_len_q == MIC_CNT_W'(MIC_PULSE_CYC);
  endproperty
  a_mic_full: assert property (p_mic_full)
    else $error("accessory pulse length wrong");

  // sequencer pulse tracks its event one cycle on
  property p_wseq;
    @(posedge sys_clk) disable iff (!rst_b)
      wseq_all_done |=> wseq_q;
  endproperty
  a_wseq: assert property (p_wseq)
    else $error("sequencer pulse missing");
endmodule

// ### gfsm_pkg.sv
// shared constants for the general-purpose pin function multiplexer
package gfsm_pkg;
  localparam int GFSM_NUM_PINS = 5;
  localparam int GFSM_FN_W = 7;
  localparam int GFSM_NUM_SRC = 40;
  // function codes
  localparam logic [6:0] FN_NONE = 7'h00;
  localparam logic [6:0] FN_LOGIC = 7'h01;
  localparam logic [6:0] FN_IRQ_A = 7'h02;
  localparam logic [6:0] FN_IRQ_B = 7'h03;
  localparam logic [6:0] FN_DCLK = 7'h04;
  localparam logic [6:0] FN_LOOP_A_CLK = 7'h05;
  localparam logic [6:0] FN_LOOP_B_CLK = 7'h06;
  localparam logic [6:0] FN_SPDIF = 7'h07;
  localparam logic [6:0] FN_PWM_A = 7'h08;
  localparam logic [6:0] FN_PWM_B = 7'h09;
  localparam logic [6:0] FN_SYS_UNDER = 7'h0A;
  localparam logic [6:0] FN_ASY_UNDER = 7'h0B;
  localparam logic [6:0] FN_LOOP_A_LOCK = 7'h0C;
  localparam logic [6:0] FN_LOOP_B_LOCK = 7'h0D;
  localparam logic [6:0] FN_LOOP_A_OK = 7'h0F;
  localparam logic [6:0] FN_LOOP_B_OK = 7'h10;
  localparam logic [6:0] FN_HP_DET = 7'h12;
  localparam logic [6:0] FN_MIC_DET = 7'h13;
  localparam logic [6:0] FN_WSEQ_DONE = 7'h15;
  localparam logic [6:0] FN_CIF_ERR = 7'h16;
  localparam logic [6:0] FN_RC_A_LOCK = 7'h1A;
  localparam logic [6:0] FN_RC_B_LOCK = 7'h1B;
  localparam logic [6:0] FN_RC_CFG_ERR = 7'h1C;
  localparam logic [6:0] FN_DYN_SIG = 7'h1D;
  localparam logic [6:0] FN_DYN_CLIP = 7'h1E;
  localparam logic [6:0] FN_DYN_DECAY = 7'h1F;
  localparam logic [6:0] FN_DYN_GATE = 7'h20;
  localparam logic [6:0] FN_DYN_QREL = 7'h21;
  localparam logic [6:0] FN_MIX_DROP = 7'h27;
  // reset values
  localparam logic [6:0] FN_RESET = FN_LOGIC;
  localparam logic DIR_RESET = 1'b1;
  localparam logic LVL_RESET = 1'b0;
  localparam logic POL_RESET = 1'b0;
  localparam logic ODR_RESET = 1'b0;
  // default subset for the fifth pin, one bit per code below 40h (arbitrary choice)
  localparam logic [63:0] PIN5_CODE_MASK = 64'h0000_0080_3F0F_F7FF;
  // accessory pulse timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIC_PULSE_NS = 31000;
  localparam int MIC_PULSE_CYC = MIC_PULSE_NS / CLK_PERIOD_NS;
  localparam int MIC_CNT_W = 12;
endpackage

// ### gfsm_pulse_stretch.sv
// one-shot stretcher: fixed-length pulse per trigger seen while idle
`timescale 1ns/1ps
module gfsm_pulse_stretch
  import gfsm_pkg::*;
#(
  parameter int LEN = MIC_PULSE_CYC,
  parameter int CW = MIC_CNT_W
) (
  input wire logic sys_clk,   // system clock
  input wire logic rst_b,     // async reset, active low
  input wire logic trig,      // one-cycle trigger
  output logic pulse          // stretched pulse
);
  logic [CW-1:0] cnt_q;

  // load on trigger while at zero, count down to zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (trig && cnt_q == '0) begin
      cnt_q <= CW'(LEN);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign pulse = (cnt_q != '0);
endmodule

// ### gfsm_host_model.sv
// far-side model: resolves each pad from device drive, host drive and pull-up
`timescale 1ns/1ps
module gfsm_host_model (
  input wire logic [4:0] pin_out, // device pad value
  input wire logic [4:0] pin_oe,  // device drive enable
  input wire logic [4:0] drv_en,  // host drives the pad
  input wire logic [4:0] drv_val, // host drive value
  output logic [4:0] pad,         // resolved pad level
  output logic [4:0] pin_in       // level seen by the device
);
  // host drives only released pads; pull-up holds an undriven pad high
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe[i]) begin
        pad[i] = pin_out[i];
      end else if (drv_en[i]) begin
        pad[i] = drv_val[i];
      end else begin
        pad[i] = 1'b1;
      end
    end
  end
  // device reads the resolved pad
  assign pin_in = pad;
endmodule

// ### gfsm_mux_tb.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module gfsm_mux_tb;
  import gfsm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cfg_we = 1'b0;
  logic [2:0] cfg_pin = 3'h0;
  logic [6:0] cfg_code = 7'h01;
  logic cfg_dir = 1'b1;
  logic cfg_lvl = 1'b0;
  logic cfg_pol = 1'b0;
  logic cfg_od = 1'b0;
  logic [24:0] src = 25'h0;
  logic mic_evt = 1'b0;
  logic wseq_done = 1'b0;
  logic [4:0] drv_en = 5'h00;
  logic [4:0] drv_val = 5'h00;
  logic [4:0] pin_in, pin_out, pin_oe, pin_in_level, pad;
  logic [6:0] code_rd [5];
  int err_count = 0;
  int comparisons = 0;
  // plain level codes, in the order of the src bits
  localparam logic [6:0] LVL_CODES [25] = '{FN_IRQ_A, FN_IRQ_B, FN_DCLK, FN_LOOP_A_CLK,
    FN_LOOP_B_CLK, FN_SPDIF, FN_PWM_A, FN_PWM_B, FN_SYS_UNDER, FN_ASY_UNDER, FN_LOOP_A_LOCK,
    FN_LOOP_B_LOCK, FN_LOOP_A_OK, FN_LOOP_B_OK, FN_HP_DET, FN_CIF_ERR, FN_RC_A_LOCK,
    FN_RC_B_LOCK, FN_RC_CFG_ERR, FN_DYN_SIG, FN_DYN_CLIP, FN_DYN_DECAY, FN_DYN_GATE,
    FN_DYN_QREL, FN_MIX_DROP};

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  gfsm_mux u_gfsm_mux (
    .sys_clk(sys_clk), .rst_b(rst_b), .cfg_we(cfg_we), .cfg_pin(cfg_pin),
    .cfg_pin_function_code(cfg_code), .cfg_pin_direction_bit(cfg_dir),
    .cfg_pin_level_bit(cfg_lvl), .cfg_output_polarity_bit(cfg_pol),
    .cfg_output_drive_type_bit(cfg_od), .first_interrupt_line(src[0]),
    .second_interrupt_line(src[1]), .derived_clock_output(src[2]),
    .first_locked_loop_clk(src[3]), .second_locked_loop_clk(src[4]), .spdif_out(src[5]),
    .pwm_a(src[6]), .pwm_b(src[7]), .system_clock_underclk(src[8]),
    .asynchronous_clock_underclk(src[9]), .first_locked_loop_lock(src[10]),
    .second_locked_loop_lock(src[11]), .first_locked_loop_ok(src[12]),
    .second_locked_loop_ok(src[13]), .hp_detect_done(src[14]),
    .mic_accessory_detect_evt(mic_evt), .wseq_all_done(wseq_done), .cif_addr_err(src[15]),
    .first_rate_converter_lock(src[16]), .second_rate_converter_lock(src[17]),
    .async_rate_converter_cfg_err(src[18]), .first_dynamics_processor_sig(src[19]),
    .first_dynamics_processor_clip(src[20]), .first_dynamics_processor_decay(src[21]),
    .first_dynamics_processor_gate(src[22]), .first_dynamics_processor_qrel(src[23]),
    .mixer_drop(src[24]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in_level(pin_in_level), .pin_function_code_rd(code_rd)
  );

  gfsm_host_model u_gfsm_host_model (
    .pin_out(pin_out), .pin_oe(pin_oe), .drv_en(drv_en), .drv_val(drv_val),
    .pad(pad), .pin_in(pin_in)
  );

  // compare and count
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // let a registered update land
  task automatic settle();
    repeat (3) @(negedge sys_clk);
  endtask

  // one config write strobe, then wait for the pad to follow
  task automatic cfg(input logic [2:0] p, input logic [6:0] c, input logic d, input logic l,
                     input logic po, input logic od);
    @(negedge sys_clk);
    cfg_we = 1'b1;
    cfg_pin = p;
    cfg_code = c;
    cfg_dir = d;
    cfg_lvl = l;
    cfg_pol = po;
    cfg_od = od;
    @(negedge sys_clk);
    cfg_we = 1'b0;
    settle();
  endtask

  // each code in range on pin 2: only its own source may move the pad
  task automatic route(input int lo, input int hi);
    for (int k = lo; k <= hi; k++) begin
      cfg(3'h2, LVL_CODES[k], 1'b0, 1'b0, 1'b0, 1'b0);
      src = 25'h1 << k;
      settle();
      check("route hi", 8'h03, {6'h00, pin_oe[2], pin_out[2]});
      src = ~(25'h1 << k);
      settle();
      check("route lo", 8'h02, {6'h00, pin_oe[2], pin_out[2]});
    end
    src = 25'h0;
  endtask

  // reset codes and enables of every pin, pad values of pins 0 to 2
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      check("reset code", 8'h01, {1'b0, code_rd[i]});
    end
    check("reset oe out", 8'h00, {pin_oe, pin_out[2:0]});
  endtask

  // routing table, pin 0 left untouched
  task automatic t_route();
    route(0, 1);
    route(2, 2);
    route(3, 4);
    route(5, 7);
    route(8, 9);
    route(10, 11);
    route(12, 13);
    route(14, 14);
    route(15, 15);
    route(16, 17);
    route(18, 18);
    route(19, 19);
    route(20, 21);
    route(22, 22);
    route(23, 23);
    route(24, 24);
    check("pin0 code", 8'h01, {1'b0, code_rd[0]});
    check("pin0 oe", 8'h00, {7'h00, pin_oe[0]});
  endtask

  // polarity inversion and open-drain drive
  task automatic t_pol_od();
    cfg(3'h1, FN_IRQ_A, 1'b0, 1'b0, 1'b1, 1'b0);
    src = 25'h1;
    settle();
    check("pol hi", 8'h02, {6'h00, pin_oe[1], pin_out[1]});
    src = 25'h0;
    cfg(3'h3, FN_IRQ_B, 1'b0, 1'b0, 1'b0, 1'b1);
    check("od lo", 8'h04, {5'h00, pin_oe[3], pin_out[3], pad[3]});
    src = 25'h2;
    settle();
    check("od hi", 8'h01, {5'h00, pin_oe[3], pin_out[3], pad[3]});
    src = 25'h0;
  endtask

  // logic level out, then input with polarity set
  task automatic t_level();
    cfg(3'h0, FN_LOGIC, 1'b0, 1'b1, 1'b0, 1'b0);
    check("lvl out", 8'h03, {6'h00, pin_oe[0], pad[0]});
    cfg(3'h0, FN_LOGIC, 1'b0, 1'b1, 1'b1, 1'b0);
    check("lvl inv", 8'h02, {6'h00, pin_oe[0], pad[0]});
    cfg(3'h0, FN_LOGIC, 1'b1, 1'b0, 1'b1, 1'b0);
    drv_en = 5'h01;
    for (int v = 0; v < 2; v++) begin
      drv_val = 5'(v);
      settle();
      check("lvl in", 8'(v), {6'h00, pin_oe[0], pin_in_level[0]});
    end
    drv_en = 5'h00;
  endtask

  // no-function codes and the fifth pin subset
  task automatic t_nofn();
    logic [6:0] codes [4];
    codes = '{7'h00, 7'h0E, 7'h11, 7'h7F};
    src = 25'h1FFFFFF;
    for (int i = 0; i < 4; i++) begin
      cfg(3'h3, codes[i], 1'b0, 1'b1, 1'b1, 1'b0);
      check("nofn oe", 8'h00, {7'h00, pin_oe[3]});
    end
    cfg(3'h4, FN_SYS_UNDER, 1'b0, 1'b0, 1'b0, 1'b0);
    check("p5 ok", 8'h03, {6'h00, pin_oe[4], pin_out[4]});
    cfg(3'h4, FN_ASY_UNDER, 1'b0, 1'b0, 1'b0, 1'b0);
    check("p5 refused", 8'h00, {7'h00, pin_oe[4]});
    src = 25'h0;
  endtask

  // accessory pulse length with a retrigger inside it; sequencer pulse
  task automatic t_pulses();
    int n;
    cfg(3'h2, FN_MIC_DET, 1'b0, 1'b0, 1'b0, 1'b0);
    n = 0;
    for (int c = 0; c < 3300; c++) begin
      mic_evt = (c == 0 || c == 100);
      @(negedge sys_clk);
      n += int'(pin_out[2] === 1'b1);
    end
    mic_evt = 1'b0;
    check("mic len lo", 8'(MIC_PULSE_CYC), 8'(n));
    check("mic len hi", 8'(MIC_PULSE_CYC >> 8), 8'(n >> 8));
    cfg(3'h2, FN_WSEQ_DONE, 1'b0, 1'b0, 1'b0, 1'b0);
    n = 0;
    for (int c = 0; c < 10; c++) begin
      wseq_done = (c == 0);
      @(negedge sys_clk);
      n += int'(pin_out[2] === 1'b1);
    end
    wseq_done = 1'b0;
    check("wseq len", 8'h01, 8'(n));
  endtask

  // main sequence
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    settle();
    t_reset();
    t_route();
    t_pol_od();
    t_level();
    t_nofn();
    t_pulses();
    conclude();
  end
endmodule
